// *** oic_pkg.sv ***
// Constants, types and register map of the pulse monitor indicator controller.
// Assumes a 100 MHz core clock; all slow timing counts in tenths of a second.
package oic_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TENTH_NS = 100_000_000;
   localparam int TENTH_CYC = (TENTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TENTH_MS = 100;
   localparam int REFRESH_MS = 1500;
   localparam int FREEZE_MS = 10000;
   localparam int HOLD_OFF_MS = 2000;
   localparam int AUTO_OFF_MS = 600000;
   localparam int FLASH_MS = 100;
   localparam logic [12:0] REFRESH_T = 13'(REFRESH_MS / TENTH_MS);
   localparam logic [12:0] FREEZE_T = 13'(FREEZE_MS / TENTH_MS);
   localparam logic [12:0] HOLD_OFF_T = 13'(HOLD_OFF_MS / TENTH_MS);
   localparam logic [12:0] AUTO_OFF_T = 13'(AUTO_OFF_MS / TENTH_MS);
   localparam logic [12:0] FLASH_T = 13'(FLASH_MS / TENTH_MS);
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam int CTRL_OFF_BIT = 0;
   localparam int CTRL_LAMP_EN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;
   localparam int IRQ_W = 4;
   localparam int IRQ_PULSE = 0;
   localparam int IRQ_DASH = 1;
   localparam int IRQ_AUTO_OFF = 2;
   localparam int IRQ_CRIT = 3;
   localparam logic [3:0] DIG_DASH = 4'hA;
   localparam logic [3:0] DIG_BLANK = 4'hF;
   localparam logic [1:0] GR_GOOD = 2'h0;
   localparam logic [1:0] GR_MARG = 2'h1;
   typedef enum logic [2:0] {
      DM_LIVE = 3'h0,
      DM_FREEZE = 3'h1,
      DM_DASH = 3'h3,
      DM_BLANK = 3'h2,
      DM_OFF = 3'h6
   } oic_mode_t;
   typedef struct packed {
      logic red;
      logic amber;
      logic green;
   } oic_lamp_t;
   typedef struct packed {
      logic [3:0] d2;
      logic [3:0] d1;
      logic [3:0] d0;
   } oic_disp_t;
   localparam oic_disp_t DISP_DASHED = {DIG_BLANK, DIG_DASH, DIG_BLANK};
   localparam oic_disp_t DISP_BLANK = {DIG_BLANK, DIG_BLANK, DIG_BLANK};
endpackage : oic_pkg

// *** oic_tick.sv ***
// Free-running divider giving a one-cycle enable every tenth of a second.
// Assumes the single core clock; CYC may be shortened for simulation.
`timescale 1ns/1ns
module oic_tick #(
   parameter int CYC = 10
) (
   input wire logic core_clk,
   input wire logic rst_n,
   output logic tick
);
   localparam int W = (CYC > 1) ? $clog2(CYC) : 1;
   localparam logic [W-1:0] LAST = W'(CYC - 1);
   logic [W-1:0] cnt_q;
   wire at_end = (cnt_q == LAST);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else begin
         cnt_q <= at_end ? '0 : cnt_q + 1'b1;
         tick <= at_end;
      end
   end
endmodule : oic_tick

// *** oic_ctrl.sv ***
// Indicator and power-state controller: readouts, quality lamp, power button, AHB-Lite registers.
// Measurement engine inputs are on core_clk; the power button is an asynchronous pin.
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
module oic_ctrl
   import oic_pkg::*;
#(
   parameter int TICK_CYC = TENTH_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic pulse_evt,
   input wire logic [1:0] grade,
   input wire logic sensor_fault,
   input wire logic batt_low,
   input wire logic batt_crit,
   input wire oic_disp_t spo2_meas,
   input wire oic_disp_t rate_meas,
   input wire logic pwr_btn,
   output oic_disp_t spo2_disp,
   output oic_disp_t rate_disp,
   output oic_lamp_t lamp,
   output logic batt_led,
   output logic power_on,
   output logic irq
);
   logic tick;
   oic_tick #(.CYC(TICK_CYC)) u_tick (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   // Button synchroniser: a change counts once stages two and three agree
   logic btn_s1_q, btn_s2_q, btn_s3_q, btn_q, btn_prev_q, lock_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         btn_s1_q <= 1'b0;
         btn_s2_q <= 1'b0;
         btn_s3_q <= 1'b0;
         btn_q <= 1'b0;
         btn_prev_q <= 1'b0;
      end else begin
         btn_s1_q <= pwr_btn;
         btn_s2_q <= btn_s1_q;
         btn_s3_q <= btn_s2_q;
         if (btn_s2_q == btn_s3_q) btn_q <= btn_s3_q;
         btn_prev_q <= btn_q;
      end
   end
   wire btn_release = btn_prev_q & ~btn_q;

   // Registers
   logic [1:0] ctrl_q;
   logic [IRQ_W-1:0] istat_q, imask_q;
   oic_mode_t mode_q, mode_d;
   logic [12:0] bad_cnt_q, crit_cnt_q, inact_cnt_q, hold_cnt_q, refresh_cnt_q, flash_cnt_q;

   // Bus address phase
   logic dp_wr_q;
   logic [7:0] dp_addr_q;
   wire ap_valid = hsel & htrans[1] & hready;
   wire ap_rd = ap_valid & ~hwrite;
   wire [7:0] ap_addr = haddr[7:0];
   wire rd_istat = ap_rd & (ap_addr == REG_IRQ_STAT);
   wire wr_ctrl = dp_wr_q & (dp_addr_q == REG_CTRL);
   wire wr_mask = dp_wr_q & (dp_addr_q == REG_IRQ_MASK);
   wire sw_off = wr_ctrl & hwdata[CTRL_OFF_BIT];
   wire lamp_en = ctrl_q[CTRL_LAMP_EN_BIT];
   wire [31:0] status_word = {24'h0, 1'b0, batt_crit, batt_low, sensor_fault, power_on, mode_q};
   wire [31:0] rd_word = (ap_addr == REG_CTRL) ? {30'h0, ctrl_q} :
                         (ap_addr == REG_STATUS) ? status_word :
                         (ap_addr == REG_IRQ_STAT) ? {28'h0, istat_q} :
                         (ap_addr == REG_IRQ_MASK) ? {28'h0, imask_q} : 32'h0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_wr_q <= 1'b0;
         dp_addr_q <= 8'h00;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dp_wr_q <= ap_valid & hwrite & (hsize == 3'h2);
         if (ap_valid) dp_addr_q <= ap_addr;
         if (ap_rd) hrdata <= rd_word;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
         imask_q <= '0;
      end else begin
         if (wr_ctrl) ctrl_q <= {hwdata[CTRL_LAMP_EN_BIT], 1'b0};
         if (wr_mask) imask_q <= hwdata[IRQ_W-1:0];
      end
   end

   // Condition and timeout counters on the shared tick
   wire grade_bad = ~(grade == GR_GOOD || grade == GR_MARG);
   wire bad = sensor_fault | grade_bad;
   function automatic logic [12:0] oic_count(input logic run, input logic [12:0] c,
                                             input logic step, input logic [12:0] lim);
      oic_count = !run ? 13'h0 : (step && c < lim) ? c + 13'h1 : c;
   endfunction : oic_count

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bad_cnt_q <= 13'h0;
         crit_cnt_q <= 13'h0;
         inact_cnt_q <= 13'h0;
         hold_cnt_q <= 13'h0;
      end else begin
         bad_cnt_q <= oic_count(power_on & bad, bad_cnt_q, tick, FREEZE_T);
         crit_cnt_q <= oic_count(power_on & batt_crit, crit_cnt_q, tick, AUTO_OFF_T);
         inact_cnt_q <= oic_count(mode_q == DM_DASH, inact_cnt_q, tick, AUTO_OFF_T);
         hold_cnt_q <= oic_count(power_on & btn_q, hold_cnt_q, tick, HOLD_OFF_T);
      end
   end

   // Power state
   wire hold_off = hold_cnt_q >= HOLD_OFF_T;
   wire crit_off = crit_cnt_q >= AUTO_OFF_T;
   wire idle_off = inact_cnt_q >= AUTO_OFF_T;
   wire turn_off = power_on & (hold_off | crit_off | idle_off | sw_off);
   wire turn_on = ~power_on & btn_release & ~lock_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_on <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         if (turn_off) power_on <= 1'b0;
         else if (turn_on) power_on <= 1'b1;
         // The release ending a hold-off press must not power the unit back on
         if (turn_off & btn_q) lock_q <= 1'b1;
         else if (~btn_q) lock_q <= 1'b0;
      end
   end

   // Display mode
   always_comb begin
      if (!power_on || turn_off) mode_d = DM_OFF;
      else if (batt_crit) mode_d = DM_BLANK;
      else if (bad && bad_cnt_q >= FREEZE_T) mode_d = DM_DASH;
      else if (bad) mode_d = DM_FREEZE;
      else mode_d = DM_LIVE;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) mode_q <= DM_OFF;
      else mode_q <= mode_d;
   end

   // Readout values: held copies refresh only while live
   oic_disp_t spo2_hold_q, rate_hold_q;
   wire refresh_due = tick && refresh_cnt_q >= REFRESH_T - 13'h1;
   wire live_entry = (mode_d == DM_LIVE) && (mode_q != DM_LIVE);
   wire load_live = (mode_d == DM_LIVE) && (refresh_due || live_entry);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         refresh_cnt_q <= 13'h0;
         spo2_hold_q <= DISP_DASHED;
         rate_hold_q <= DISP_DASHED;
      end else begin
         if (live_entry || refresh_due) refresh_cnt_q <= 13'h0;
         else if (tick) refresh_cnt_q <= refresh_cnt_q + 13'h1;
         if (load_live) begin
            spo2_hold_q <= spo2_meas;
            rate_hold_q <= rate_meas;
         end
      end
   end

   oic_disp_t spo2_d, rate_d;
   always_comb begin
      spo2_d = spo2_hold_q;
      rate_d = rate_hold_q;
      case (mode_d)
         DM_LIVE: begin
            if (load_live) begin
               spo2_d = spo2_meas;
               rate_d = rate_meas;
            end
         end
         DM_FREEZE: begin
            if (sensor_fault) spo2_d.d2 = DIG_DASH;
         end
         DM_DASH: begin
            spo2_d = DISP_DASHED;
            rate_d = DISP_DASHED;
         end
         DM_BLANK: begin
            spo2_d = DISP_BLANK;
            rate_d = DISP_BLANK;
         end
         default: begin
            spo2_d = DISP_BLANK;
            rate_d = DISP_BLANK;
         end
      endcase
   end

   // Quality lamp: one flash per pulse, colour caught at the pulse
   wire take_pulse = pulse_evt & power_on & ~turn_off & lamp_en;
   wire [1:0] eff_grade = (batt_crit && grade == GR_GOOD) ? GR_MARG : grade;
   oic_lamp_t colour;
   assign colour = '{red: ~(eff_grade == GR_GOOD || eff_grade == GR_MARG),
                     amber: eff_grade == GR_MARG, green: eff_grade == GR_GOOD};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lamp <= '0;
         flash_cnt_q <= 13'h0;
         spo2_disp <= DISP_BLANK;
         rate_disp <= DISP_BLANK;
         batt_led <= 1'b0;
      end else begin
         if (take_pulse) begin
            lamp <= colour;
            flash_cnt_q <= FLASH_T;
         end else if (!power_on || (tick && flash_cnt_q <= 13'h1)) begin
            lamp <= '0;
            flash_cnt_q <= 13'h0;
         end else if (tick) begin
            flash_cnt_q <= flash_cnt_q - 13'h1;
         end
         spo2_disp <= spo2_d;
         rate_disp <= rate_d;
         batt_led <= power_on & (batt_low | batt_crit);
      end
   end

   // Interrupts: sticky events, cleared by reading, a new event wins over the clear
   wire [IRQ_W-1:0] ev;
   assign ev[IRQ_PULSE] = take_pulse;
   assign ev[IRQ_DASH] = (mode_d == DM_DASH) && (mode_q != DM_DASH);
   assign ev[IRQ_AUTO_OFF] = turn_off & (crit_off | idle_off);
   assign ev[IRQ_CRIT] = power_on & batt_crit & (crit_cnt_q == 13'h0);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         istat_q <= '0;
         irq <= 1'b0;
      end else begin
         istat_q <= (istat_q & ~{IRQ_W{rd_istat}}) | ev;
         irq <= |(((istat_q & ~{IRQ_W{rd_istat}}) | ev) & imask_q);
      end
   end

   // Checks
   a_pulse_flash: assert property (@(posedge core_clk) disable iff (!rst_n)
      take_pulse |=> (lamp != '0) && (flash_cnt_q == FLASH_T))
      else $error("pulse did not start a flash");
   a_lamp_colour: assert property (@(posedge core_clk) disable iff (!rst_n)
      take_pulse && grade == GR_MARG |=> lamp.amber && !lamp.green && !lamp.red)
      else $error("marginal pulse not amber");
   a_crit_no_green: assert property (@(posedge core_clk) disable iff (!rst_n)
      take_pulse && batt_crit |=> !lamp.green ##1 (mode_q != DM_BLANK || spo2_disp == DISP_BLANK))
      else $error("green lamp or readout on critical battery");
   a_freeze_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      mode_q == DM_FREEZE && $past(mode_q) == DM_FREEZE
      && $past(sensor_fault) == $past(sensor_fault, 2)
      |-> $stable(rate_disp) && $stable(spo2_disp))
      else $error("readout changed while frozen");
   a_dash_after: assert property (@(posedge core_clk) disable iff (!rst_n)
      power_on && !turn_off && !batt_crit && bad && bad_cnt_q >= FREEZE_T
      |=> mode_q == DM_DASH && rate_disp == DISP_DASHED && spo2_disp == DISP_DASHED)
      else $error("no centred dashes after freeze");
   a_fault_dash: assert property (@(posedge core_clk) disable iff (!rst_n)
      mode_d == DM_FREEZE && sensor_fault |=> spo2_disp.d2 == DIG_DASH)
      else $error("fault dash missing");
   a_live_again: assert property (@(posedge core_clk) disable iff (!rst_n)
      power_on && !turn_off && !bad && !batt_crit && mode_q != DM_LIVE
      |=> mode_q == DM_LIVE && spo2_disp == $past(spo2_meas) && rate_disp == $past(rate_meas))
      else $error("readouts did not resume");
   a_power_on: assert property (@(posedge core_clk) disable iff (!rst_n)
      turn_on |=> power_on)
      else $error("release did not power on");
   a_hold_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      power_on && hold_cnt_q == HOLD_OFF_T |=> !power_on ##1 !power_on)
      else $error("hold did not power off");
   a_auto_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      power_on && (crit_cnt_q == AUTO_OFF_T || inact_cnt_q == AUTO_OFF_T) |=> !power_on)
      else $error("auto power off missed");
   a_batt_led: assert property (@(posedge core_clk) disable iff (!rst_n)
      power_on && batt_low |=> batt_led)
      else $error("low battery lamp dark");
   a_timer_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
      !bad |=> bad_cnt_q == 13'h0)
      else $error("bad signal timer did not restart");
   a_refresh_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
      refresh_cnt_q <= REFRESH_T)
      else $error("refresh period overrun");
   a_lamp_red: assert property (@(posedge core_clk) disable iff (!rst_n)
      take_pulse && grade[1] |=> lamp.red && !lamp.amber && !lamp.green)
      else $error("inadequate pulse not red");
   a_lamp_green: assert property (@(posedge core_clk) disable iff (!rst_n)
      take_pulse && grade == GR_GOOD && !batt_crit |=> lamp.green && !lamp.amber && !lamp.red)
      else $error("good pulse not green");
   a_flash_end: assert property (@(posedge core_clk) disable iff (!rst_n)
      !take_pulse && tick && flash_cnt_q <= 13'h1 |=> lamp == '0)
      else $error("flash did not end");
   a_dark_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      !power_on |=> lamp == '0)
      else $error("lamp lit while off");
   a_crit_blank: assert property (@(posedge core_clk) disable iff (!rst_n)
      power_on && !turn_off && batt_crit |=> spo2_disp == DISP_BLANK && rate_disp == DISP_BLANK)
      else $error("readouts not blank on critical battery");
   a_freeze_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
      power_on && !turn_off && !batt_crit && bad && bad_cnt_q < FREEZE_T |=> mode_q == DM_FREEZE)
      else $error("bad signal did not freeze readouts");
   a_lock_release: assert property (@(posedge core_clk) disable iff (!rst_n)
      !power_on && lock_q |=> !power_on)
      else $error("hold-off release powered on");
   c_dash_reached: cover property (@(posedge core_clk) disable iff (!rst_n)
      mode_q == DM_FREEZE ##1 mode_q == DM_DASH);
   c_hold_off: cover property (@(posedge core_clk) disable iff (!rst_n) power_on ##1 hold_off);
   c_irq_read: cover property (@(posedge core_clk) disable iff (!rst_n) irq && rd_istat);
   c_crit_blank: cover property (@(posedge core_clk) disable iff (!rst_n) mode_q == DM_BLANK);
   c_fault_freeze: cover property (@(posedge core_clk) disable iff (!rst_n)
      mode_q == DM_FREEZE && sensor_fault);
endmodule : oic_ctrl

// *** oic_front_model.sv ***
// Far-side model: beat source of the measurement engine and the operator's power button.
// Assumes the bench sets beat spacing and press length; all on core_clk.
`timescale 1ns/1ns
module oic_front_model
   import oic_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] beat_gap,
   input wire logic press_go,
   input wire logic [15:0] press_cyc,
   output logic pulse_evt,
   output logic pwr_btn,
   output logic press_busy
);
   logic [7:0] beat_q;
   logic [15:0] held_q;
   // One-cycle event per detected beat
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         beat_q <= 8'h00;
         pulse_evt <= 1'b0;
      end else begin
         beat_q <= (beat_q >= beat_gap) ? 8'h00 : beat_q + 8'h01;
         pulse_evt <= (beat_q == beat_gap);
      end
   end
   // Button held for press_cyc cycles
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         held_q <= 16'h0000;
      end else if (press_go) begin
         held_q <= press_cyc;
      end else if (held_q != 16'h0000) begin
         held_q <= held_q - 16'h0001;
      end
   end
   assign press_busy = (held_q != 16'h0000);
   // Pin moves off the clock edge, like a real contact
   assign #3 pwr_btn = press_busy;
endmodule : oic_front_model

// *** oximeter_indicator_control_test.sv ***
// Self-checking bench for the indicator controller through its ports and registers.
// Assumes a shortened tick of four cycles; the front model gives beats and presses.
`timescale 1ns/1ns
module oximeter_indicator_control_test;
   import oic_pkg::*;
   localparam int TK = 4;
   logic core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, press_go, press_busy;
   logic sensor_fault, batt_low, batt_crit, pwr_btn, pulse_evt, batt_led, power_on, irq, pc;
   logic pl, len;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, grade, pg;
   logic [2:0] hsize;
   logic [7:0] beat_gap;
   logic [15:0] press_cyc;
   oic_disp_t spo2_meas, rate_meas, spo2_disp, rate_disp, da, db, dc, dd;
   oic_lamp_t lamp;
   int errors, samples_checked, n;
   assign hready = hreadyout;
   oic_ctrl #(.TICK_CYC(TK)) u_oic_ctrl (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pulse_evt(pulse_evt), .grade(grade), .sensor_fault(sensor_fault), .batt_low(batt_low),
      .batt_crit(batt_crit), .spo2_meas(spo2_meas), .rate_meas(rate_meas), .pwr_btn(pwr_btn),
      .spo2_disp(spo2_disp), .rate_disp(rate_disp), .lamp(lamp), .batt_led(batt_led),
      .power_on(power_on), .irq(irq));
   oic_front_model u_oic_front_model (.core_clk(core_clk), .rst_n(rst_n), .beat_gap(beat_gap),
      .press_go(press_go), .press_cyc(press_cyc), .pulse_evt(pulse_evt), .pwr_btn(pwr_btn),
      .press_busy(press_busy));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic give_verdict();
      if (errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic cmp_disp(input oic_disp_t s, input oic_disp_t r);
      cmp({20'h0, spo2_disp}, {20'h0, s});
      cmp({20'h0, rate_disp}, {20'h0, r});
   endtask : cmp_disp
   function automatic oic_disp_t rand_disp();
      return {4'($urandom_range(9)), 4'($urandom_range(9)), 4'($urandom_range(9))};
   endfunction : rand_disp
   function automatic oic_lamp_t exp_lamp(input logic [1:0] g, input logic c);
      if (g[1]) return 3'b100;
      if (g == GR_MARG || c) return 3'b010;
      return 3'b001;
   endfunction : exp_lamp
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hready !== 1'b1);
      rd = hrdata;
      cmp({31'h0, hresp}, 32'h0);
   endtask : bus
   task automatic wait_pw(input logic v, input int lim);
      n = 0;
      while (power_on !== v && n < lim) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      cmp({31'h0, power_on}, {31'h0, v});
   endtask : wait_pw
   task automatic wait_disp(input oic_disp_t s, input oic_disp_t r, input int lim);
      n = 0;
      while ((spo2_disp !== s || rate_disp !== r) && n < lim) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      cmp_disp(s, r);
   endtask : wait_disp
   task automatic press(input int c);
      @(posedge core_clk);
      press_cyc <= 16'(c);
      press_go <= 1'b1;
      @(posedge core_clk);
      press_go <= 1'b0;
      repeat (c + 2) @(posedge core_clk);
      #1;
   endtask : press
   task automatic go(input int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask : go
   // Lamp must be dark before each beat and after it lit in the grade colour, or still dark while the lamp is disabled
   always @(posedge core_clk) begin
      if (pulse_evt === 1'b1 && power_on === 1'b1) begin
         pg = grade;
         pc = batt_crit;
         pl = len;
         cmp({29'h0, lamp}, 32'h0);
         #1;
         if (power_on === 1'b1 && pl) cmp({29'h0, lamp}, {29'h0, exp_lamp(pg, pc)});
         if (power_on === 1'b1 && !pl) cmp({29'h0, lamp}, 32'h0);
      end
   end
   initial begin
      #(70000 * 10);
      errors++;
      give_verdict();
   end
   initial begin
      rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; grade = GR_GOOD; sensor_fault = 1'b0; batt_low = 1'b0; batt_crit = 1'b0;
      spo2_meas = 12'h0; rate_meas = 12'h0; press_go = 1'b0; press_cyc = 16'h0;
      beat_gap = 8'h1E; errors = 0; samples_checked = 0;
      len = 1'b1;
      void'($urandom(32'h7647));
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      cmp_disp(DISP_BLANK, DISP_BLANK);
      cmp({26'h0, lamp, batt_led, power_on, irq}, 32'h0);
      bus(1'b0, REG_CTRL, 32'h0);
      cmp(rd, {30'h0, CTRL_RESET});
      bus(1'b0, REG_STATUS, 32'h0);
      cmp(rd, {29'h0, DM_OFF});
      bus(1'b1, 8'h10, 32'hFFFFFFFF);
      bus(1'b0, 8'h10, 32'h0);
      cmp(rd, 32'h0);
      bus(1'b1, REG_IRQ_MASK, 32'h0000000A);
      bus(1'b0, REG_IRQ_MASK, 32'h0);
      cmp(rd, 32'h0000000A);
      beat_gap <= 8'($urandom_range(60, 20));
      press(8);
      wait_pw(1'b1, 40);
      go(3);
      da = rand_disp();
      db = rand_disp();
      spo2_meas <= da;
      rate_meas <= db;
      wait_disp(da, db, 70);
      da.d2 = (da.d2 == 4'h9) ? 4'h0 : da.d2 + 4'h1;
      @(posedge core_clk);
      spo2_meas <= da;
      wait_disp(da, db, 80);
      cmp(32'(n >= 57 && n <= 61), 32'h1);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         grade <= 2'(i);
         go(100);
      end
      grade <= GR_GOOD;
      go(10);
      dc = rand_disp();
      dd = rand_disp();
      grade <= 2'h2;
      spo2_meas <= dc;
      rate_meas <= dd;
      go(40 * TK);
      cmp_disp(da, db);
      bus(1'b0, REG_STATUS, 32'h0);
      cmp(rd, {28'h0, 1'b1, DM_FREEZE});
      wait_disp(DISP_DASHED, DISP_DASHED, 90 * TK);
      cmp(32'(n > 55 * TK), 32'h1);
      cmp({31'h0, irq}, 32'h1);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      cmp({31'h0, rd[IRQ_DASH]}, 32'h1);
      go(70);
      cmp({31'h0, irq}, 32'h0);
      grade <= GR_GOOD;
      wait_disp(dc, dd, 10);
      sensor_fault <= 1'b1;
      spo2_meas <= da;
      rate_meas <= db;
      go(40 * TK);
      cmp_disp({DIG_DASH, dc.d1, dc.d0}, dd);
      wait_disp(DISP_DASHED, DISP_DASHED, 70 * TK);
      wait_pw(1'b0, 6010 * TK);
      cmp(32'(n > 5990 * TK), 32'h1);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      cmp({31'h0, rd[IRQ_AUTO_OFF]}, 32'h1);
      sensor_fault <= 1'b0;
      press(8);
      wait_pw(1'b1, 40);
      batt_low <= 1'b1;
      go(3);
      cmp({31'h0, batt_led}, 32'h1);
      batt_low <= 1'b0;
      batt_crit <= 1'b1;
      wait_disp(DISP_BLANK, DISP_BLANK, 10);
      cmp({31'h0, batt_led}, 32'h1);
      wait_pw(1'b0, 6010 * TK);
      cmp(32'(n > 5990 * TK), 32'h1);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      cmp({30'h0, rd[IRQ_CRIT:IRQ_AUTO_OFF]}, 32'h3);
      batt_crit <= 1'b0;
      press(8);
      wait_pw(1'b1, 40);
      press(10 * TK);
      go(10 * TK);
      cmp({31'h0, power_on}, 32'h1);
      fork
         press(40 * TK);
         begin
            go(15 * TK + 2);
            cmp({31'h0, power_on}, 32'h1);
            wait_pw(1'b0, 10 * TK);
         end
      join
      go(20);
      cmp({31'h0, power_on}, 32'h0);
      press(8);
      wait_pw(1'b1, 40);
      bus(1'b1, REG_CTRL, 32'h0);
      len <= 1'b0;
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      go(150);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      cmp({31'h0, rd[IRQ_PULSE]}, 32'h0);
      bus(1'b1, REG_CTRL, 32'h2);
      len <= 1'b1;
      go(150);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      cmp({31'h0, rd[IRQ_PULSE]}, 32'h1);
      bus(1'b1, REG_CTRL, 32'h3);
      wait_pw(1'b0, 5);
      bus(1'b0, REG_CTRL, 32'h0);
      cmp(rd, {30'h0, CTRL_RESET});
      give_verdict();
   end
endmodule : oximeter_indicator_control_test
